/* capture_compare_pwm_control_defines.svh */
// register offsets, field positions, mode codes and reset values of the capture/compare/pwm unit
`ifndef CAPTURE_COMPARE_PWM_CONTROL_DEFINES_SVH
`define CAPTURE_COMPARE_PWM_CONTROL_DEFINES_SVH

`define ADDR_W             12
`define OFS_UNIT_CONTROL   12'h000
`define OFS_CAPTURE_SELECT 12'h004
`define OFS_VALUE_LOW      12'h008
`define OFS_VALUE_HIGH     12'h00c
`define OFS_IRQ_STATUS     12'h010
`define OFS_IRQ_MASK       12'h014

`define CTRL_ENABLE_BIT    7
`define CTRL_OUTPUT_BIT    5
`define CTRL_FORMAT_BIT    4
`define CTRL_WRITE_MASK    8'h9f
`define CAPSEL_WRITE_MASK  8'h07
`define CTRL_RESET         8'h00
`define CAPSEL_RESET       8'h00
`define VALUE_RESET        8'h00
`define IRQ_EVENT_BIT      0

`define MODE_OFF           4'h0
`define MODE_TOGGLE_CLEAR  4'h1
`define MODE_TOGGLE        4'h2
`define MODE_CAP_EDGE      4'h3
`define MODE_CAP_FALL      4'h4
`define MODE_CAP_RISE      4'h5
`define MODE_CAP_RISE4     4'h6
`define MODE_CAP_RISE16    4'h7
`define MODE_SET_ON_MATCH  4'h8
`define MODE_CLR_ON_MATCH  4'h9
`define MODE_PULSE         4'ha
`define MODE_PULSE_CLEAR   4'hb
`define PRESCALE_4_LAST    4'h3
`define PRESCALE_16_LAST   4'hf

`endif

/* capture_compare_pwm_control_pkg.sv */
// types shared by the capture/compare/pwm unit
package capture_compare_pwm_control_pkg;

	typedef enum logic [1:0] {
		kind_off,
		kind_capture,
		kind_compare,
		kind_pwm
	} unit_kind_t;

	typedef struct packed {
		logic [3:0] logic_cell_outputs;
		logic       pin_change_event;
		logic       comparator_two_output;
		logic       comparator_one_output;
		logic       mapped_capture_pin;
	} capture_sources_t;

	typedef struct packed {
		logic [7:0] timer_one_high;
		logic [7:0] timer_one_low;
	} timer_one_t;

endpackage

/* capture_compare_pwm_control.sv */
// capture/compare/pwm unit: apb registers, capture, compare match, pwm output and events
//
// Notes on behaviour
// - control bit 5 reads the live output level; writes to it are ignored.
// - control bits 3..0 select capture, compare or pwm behaviour.
// - mode codes 1100 to 1111 run pwm on the timer two time base.
// - capture event loads low value byte from timer one low byte.
// - compare mode matches both value bytes against timer one low and high bytes.
// - pwm right aligned: low byte holds eight least significant width bits.
// - pwm left aligned: low bits 7..6 are width lsbs, 5..0 ignored.
// - every capture, compare or pwm event sets the unit event flag.
// - when selected as converter trigger, each unit event starts a conversion.
// - three-bit field picks pin, comparator one/two, pin change or logic cells.
// - capture select bits 7..3 and control bit 6 always read zero.
// - pwm right aligned: high bits 1..0 are width msbs, 7..2 unused.
// - capture event loads high value byte from timer one high byte.
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_pwm_control_defines.svh"

module capture_compare_pwm_control
	import capture_compare_pwm_control_pkg::*;
(
	input  wire logic                sys_clk_i,
	input  wire logic                reset_n_i,
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [`ADDR_W-1:0]  paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	input  wire timer_one_t          timer_one_i,
	input  wire logic                period_start_i,
	input  wire logic [9:0]          pwm_time_base_i,
	input  wire capture_sources_t    capture_sources_i,
	input  wire logic                adc_source_selected_i,
	output logic                     unit_output_o,
	output logic                     unit_event_o,
	output logic                     adc_trigger_o,
	output logic                     timer_one_clear_o,
	output logic                     irq_o
);

	function automatic unit_kind_t mode_kind(input logic [3:0] m);
		case (m)
			`MODE_OFF: begin
				mode_kind = kind_off;
			end
			`MODE_CAP_EDGE, `MODE_CAP_FALL, `MODE_CAP_RISE,
			`MODE_CAP_RISE4, `MODE_CAP_RISE16: begin
				mode_kind = kind_capture;
			end
			default: begin
				mode_kind = m[3] & m[2] ? kind_pwm : kind_compare;
			end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// registers and decode

	logic [7:0] control_r;
	logic [7:0] capture_select_r;
	logic [7:0] value_low_r;
	logic [7:0] value_high_r;
	logic       irq_status_r;
	logic       irq_mask_r;
	logic       out_r;
	logic       out_nxt;
	logic       pready_r;
	logic       pslverr_r;
	logic [31:0] prdata_r;
	logic       event_r;
	logic       adc_r;
	logic       tclear_r;
	logic       irq_r;

	logic       wr_en;
	logic       rd_phase;
	logic       addr_ok;
	logic [7:0] rd_byte;
	logic [3:0] mode;
	unit_kind_t kind;
	logic       active;

	assign mode     = control_r[3:0];
	assign kind     = mode_kind(mode);
	assign active   = control_r[`CTRL_ENABLE_BIT] & (kind != kind_off);
	assign rd_phase = psel_i & penable_i & ~pready_r;
	assign wr_en    = psel_i & penable_i & pready_r & pwrite_i & ~pslverr_r;

	always_comb begin
		addr_ok = 1'b1;
		rd_byte = 8'h00;
		case (paddr_i)
			`OFS_UNIT_CONTROL: begin
				rd_byte = {control_r[7], 1'b0, out_r, control_r[4:0]};
			end
			`OFS_CAPTURE_SELECT: begin
				rd_byte = {5'h00, capture_select_r[2:0]};
			end
			`OFS_VALUE_LOW: begin
				rd_byte = value_low_r;
			end
			`OFS_VALUE_HIGH: begin
				rd_byte = value_high_r;
			end
			`OFS_IRQ_STATUS: begin
				rd_byte = {7'h00, irq_status_r};
			end
			`OFS_IRQ_MASK: begin
				rd_byte = {7'h00, irq_mask_r};
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// one wait state: ready rises in the second access cycle, data captured in the first
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r <= rd_phase;
			if (rd_phase) begin
				pslverr_r <= ~addr_ok;
				prdata_r  <= {24'h00_0000, rd_byte};
			end else begin
				pslverr_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			control_r        <= `CTRL_RESET;
			capture_select_r <= `CAPSEL_RESET;
			irq_mask_r       <= 1'b0;
		end else if (wr_en) begin
			if (paddr_i == `OFS_UNIT_CONTROL) begin
				control_r <= pwdata_i[7:0] & `CTRL_WRITE_MASK;
			end
			if (paddr_i == `OFS_CAPTURE_SELECT) begin
				capture_select_r <= pwdata_i[7:0] & `CAPSEL_WRITE_MASK;
			end
			if (paddr_i == `OFS_IRQ_MASK) begin
				irq_mask_r <= pwdata_i[`IRQ_EVENT_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// capture trigger selection and edge detection

	logic       trig_sel;
	logic       trig_prev_r;
	logic       trig_rise;
	logic       trig_fall;
	logic [3:0] presc_r;
	logic       capture_hit;

	always_comb begin
		case (capture_select_r[2:0])
			3'h0: trig_sel = capture_sources_i.mapped_capture_pin;
			3'h1: trig_sel = capture_sources_i.comparator_one_output;
			3'h2: trig_sel = capture_sources_i.comparator_two_output;
			3'h3: trig_sel = capture_sources_i.pin_change_event;
			default: trig_sel = capture_sources_i.logic_cell_outputs[capture_select_r[1:0]];
		endcase
	end

	assign trig_rise = trig_sel & ~trig_prev_r;
	assign trig_fall = ~trig_sel & trig_prev_r;

	always_comb begin
		capture_hit = 1'b0;
		if (active && kind == kind_capture) begin
			case (mode)
				`MODE_CAP_EDGE:   capture_hit = trig_rise | trig_fall;
				`MODE_CAP_FALL:   capture_hit = trig_fall;
				`MODE_CAP_RISE:   capture_hit = trig_rise;
				`MODE_CAP_RISE4:  capture_hit = trig_rise & (presc_r == `PRESCALE_4_LAST);
				`MODE_CAP_RISE16: capture_hit = trig_rise & (presc_r == `PRESCALE_16_LAST);
				default:          capture_hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			trig_prev_r <= 1'b0;
		end else begin
			trig_prev_r <= trig_sel;
		end
	end

	// prescaler restarts whenever the unit leaves a prescaled capture mode
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			presc_r <= 4'h0;
		end else if (!active || (mode != `MODE_CAP_RISE4 && mode != `MODE_CAP_RISE16)) begin
			presc_r <= 4'h0;
		end else if (capture_hit) begin
			presc_r <= 4'h0;
		end else if (trig_rise) begin
			presc_r <= presc_r + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// compare match, edge-qualified so a stopped timer raises one event only

	logic match_now;
	logic match_prev_r;
	logic cmp_hit;
	logic pulse_mode;
	logic clear_mode;

	assign match_now  = (value_low_r == timer_one_i.timer_one_low) &&
	                    (value_high_r == timer_one_i.timer_one_high);
	assign cmp_hit    = active && kind == kind_compare && match_now && !match_prev_r;
	assign pulse_mode = (mode == `MODE_PULSE) || (mode == `MODE_PULSE_CLEAR);
	assign clear_mode = (mode == `MODE_TOGGLE_CLEAR) || (mode == `MODE_PULSE_CLEAR);

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			match_prev_r <= 1'b0;
		end else begin
			match_prev_r <= match_now;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pwm duty assembly and period buffer

	logic [9:0] duty_value;
	logic [9:0] duty_buf_r;
	logic       pwm_start;

	assign duty_value = control_r[`CTRL_FORMAT_BIT] ?
	                    {value_high_r, value_low_r[7:6]} :
	                    {value_high_r[1:0], value_low_r};
	assign pwm_start  = active && kind == kind_pwm && period_start_i;

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			duty_buf_r <= 10'h000;
		end else if (pwm_start) begin
			duty_buf_r <= duty_value;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output level

	always_comb begin
		out_nxt = out_r;
		if (!active) begin
			out_nxt = 1'b0;
		end else if (kind == kind_compare) begin
			if (cmp_hit) begin
				case (mode)
					`MODE_TOGGLE_CLEAR, `MODE_TOGGLE: out_nxt = ~out_r;
					`MODE_CLR_ON_MATCH:               out_nxt = 1'b0;
					default:                          out_nxt = 1'b1;
				endcase
			end else if (pulse_mode) begin
				out_nxt = 1'b0;
			end
		end else if (kind == kind_pwm) begin
			if (pwm_start) begin
				out_nxt = (duty_value != 10'h000);
			end else if (pwm_time_base_i == duty_buf_r) begin
				out_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			out_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// value bytes: a capture wins over a software write in the same cycle

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			value_low_r  <= `VALUE_RESET;
			value_high_r <= `VALUE_RESET;
		end else if (capture_hit) begin
			value_low_r  <= timer_one_i.timer_one_low;
			value_high_r <= timer_one_i.timer_one_high;
		end else if (wr_en) begin
			if (paddr_i == `OFS_VALUE_LOW) begin
				value_low_r <= pwdata_i[7:0];
			end
			if (paddr_i == `OFS_VALUE_HIGH) begin
				value_high_r <= pwdata_i[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// events, converter trigger and interrupt

	logic unit_event;

	assign unit_event = capture_hit | cmp_hit | pwm_start;

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			event_r  <= 1'b0;
			adc_r    <= 1'b0;
			tclear_r <= 1'b0;
		end else begin
			event_r  <= unit_event;
			adc_r    <= unit_event & adc_source_selected_i;
			tclear_r <= cmp_hit & clear_mode;
		end
	end

	// set beats a write-one-to-clear landing in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			irq_status_r <= 1'b0;
		end else if (unit_event) begin
			irq_status_r <= 1'b1;
		end else if (wr_en && paddr_i == `OFS_IRQ_STATUS && pwdata_i[`IRQ_EVENT_BIT]) begin
			irq_status_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_status_r & irq_mask_r;
		end
	end

	assign prdata_o          = prdata_r;
	assign pready_o          = pready_r;
	assign pslverr_o         = pslverr_r;
	assign unit_output_o     = out_r;
	assign unit_event_o      = event_r;
	assign adc_trigger_o     = adc_r;
	assign timer_one_clear_o = tclear_r;
	assign irq_o             = irq_r;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	out_readback_a: assert property (rd_phase && paddr_i == `OFS_UNIT_CONTROL |=>
		prdata_o[`CTRL_OUTPUT_BIT] == $past(out_r))
		else $error("output bit readback wrong");
	reserved_zero_a: assert property (rd_phase && paddr_i == `OFS_CAPTURE_SELECT |=>
		prdata_o[7:3] == 5'h00)
		else $error("capture select reserved bits not zero");
	ctrl_bit6_a: assert property (control_r[6] == 1'b0)
		else $error("control bit 6 set");
	pulse_shape_a: assert property (cmp_hit && pulse_mode |=> out_r ##1 !out_r)
		else $error("compare pulse not 0-1-0");
	capture_load_a: assert property (capture_hit |=>
		{value_high_r, value_low_r} == $past(timer_one_i))
		else $error("capture did not load timer one");
	inactive_low_a: assert property (!active |=> !out_r)
		else $error("output high while inactive");
	event_flag_a: assert property (unit_event |=> event_r && irq_status_r)
		else $error("event did not set flag");
	adc_start_a: assert property (unit_event && adc_source_selected_i |=> adc_trigger_o)
		else $error("no conversion start on event");
	pwm_load_a: assert property (pwm_start |=> duty_buf_r == $past(duty_value))
		else $error("pwm duty not buffered");
	left_align_a: assert property (control_r[`CTRL_FORMAT_BIT] && $changed(value_low_r[5:0]) &&
		$stable(value_low_r[7:6]) && $stable(value_high_r) |-> $stable(duty_value))
		else $error("ignored low bits changed duty");
	mode_kind_a: assert property (mode[3:2] == 2'b11 |-> kind == kind_pwm)
		else $error("pwm code not decoded");
	apb_ready_a: assert property (rd_phase |=> pready_o ##1 !pready_o)
		else $error("apb ready not single pulse");
	irq_level_a: assert property (irq_status_r && irq_mask_r |=> irq_o)
		else $error("unmasked status without interrupt");

	capture_cov_c: cover property (capture_hit ##[1:20] capture_hit);
	compare_cov_c: cover property (cmp_hit && pulse_mode);
	pwm_cov_c:     cover property (pwm_start ##[1:40] (kind == kind_pwm && !out_r));
	irq_cov_c:     cover property (irq_o ##[1:10] !irq_status_r);

endmodule

`default_nettype wire

/* timer_source_model.sv */
// far-side model: timer one counter, timer two time base and capture source levels
`timescale 1ns/1ps
`default_nettype none

module timer_source_model
	import capture_compare_pwm_control_pkg::*;
#(
	parameter int PERIOD = 64
) (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        timer_run_i,
	input  wire logic        timer_clear_i,
	input  wire logic [7:0]  src_level_i,
	output var timer_one_t   timer_one_o,
	output logic             period_start_o,
	output logic [9:0]       time_base_o,
	output var capture_sources_t sources_o
);

////////////////////////////////////////////////////////////////////////////////
	// timer one holds while stopped so a captured value can be predicted
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || timer_clear_i) begin
			timer_one_o <= '0;
		end else if (timer_run_i) begin
			timer_one_o <= timer_one_o + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || time_base_o == 10'(PERIOD - 1)) begin
			time_base_o <= 10'h000;
		end else begin
			time_base_o <= time_base_o + 10'h001;
		end
	end

	// start of period marked while the base sits at zero
	assign period_start_o = reset_n_i && (time_base_o == 10'h000);
	assign sources_o      = capture_sources_t'(src_level_i);

endmodule

`default_nettype wire

/* capture_compare_pwm_control_tb.sv */
// self-checking bench of the capture/compare/pwm unit
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_pwm_control_defines.svh"

module capture_compare_pwm_control_tb
	import capture_compare_pwm_control_pkg::*;
;
	logic             sys_clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, q;
	logic             e, pstart, adc_sel, uout, uev, adct, t1clr, irq, run, tclr;
	logic [9:0]       tbase;
	logic [7:0]       src;
	timer_one_t       t1;
	capture_sources_t srcs;
	int               err_count, num_checks, ev_cnt, adc_cnt, hi_cnt, clr_cnt;
	int               e0, a0, h0, c0;
	logic [7:0] pc_ctrl [7] = '{8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h05, 8'h80};
	int         pc_exp  [7] = '{32, 16, 16, 4, 1, 0, 0};
	logic [3:0] cm_mode [6] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
	logic       cm_out  [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
	int         cm_clr  [6] = '{1, 0, 0, 0, 0, 1};
	logic [7:0] pw_ctrl [4] = '{8'h8c, 8'h9d, 8'h8e, 8'h9f};
	logic [7:0] pw_hi   [4] = '{8'hfc, 8'h05, 8'h00, 8'h02};
	logic [7:0] pw_lo   [4] = '{8'h1e, 8'h7f, 8'h08, 8'h00};
	int         pw_duty [4] = '{30, 21, 8, 8};

	capture_compare_pwm_control i_capture_compare_pwm_control (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .timer_one_i(t1), .period_start_i(pstart),
		.pwm_time_base_i(tbase), .capture_sources_i(srcs), .adc_source_selected_i(adc_sel),
		.unit_output_o(uout), .unit_event_o(uev), .adc_trigger_o(adct),
		.timer_one_clear_o(t1clr), .irq_o(irq));

	timer_source_model #(.PERIOD(64)) i_timer_source_model (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .timer_run_i(run),
		.timer_clear_i(tclr | t1clr), .src_level_i(src), .timer_one_o(t1),
		.period_start_o(pstart), .time_base_o(tbase), .sources_o(srcs));

////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	// counted on the falling edge, where registered outputs have settled
	always @(negedge sys_clk_i) begin
		ev_cnt  += (uev === 1'b1);
		adc_cnt += (adct === 1'b1);
		hi_cnt  += (uout === 1'b1);
		clr_cnt += (t1clr === 1'b1);
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// pready is sampled at each rising edge of the access phase; data is taken at that edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		@(posedge sys_clk_i);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge sys_clk_i);
		end
		if (n == 20) begin
			err_count++;
			wrap_up();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	initial begin
		repeat (100000) @(posedge sys_clk_i);
		err_count++;
		wrap_up();
	end

////////////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, paddr, pwdata, adc_sel, run, tclr, src} = '0;
		reset_n_i = 1'b0;
		repeat (3) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rdc(12'(i * 4), 32'h0);
		end
		wr(`OFS_UNIT_CONTROL, 8'h7f);
		rdc(`OFS_UNIT_CONTROL, 32'h1f);
		wr(`OFS_CAPTURE_SELECT, 8'hff);
		rdc(`OFS_CAPTURE_SELECT, 32'h07);
		apb(1'b0, 12'h018, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		// every trigger source: a neighbour edge is ignored, the chosen one captures
		for (int k = 0; k < 8; k++) begin
			wr(`OFS_CAPTURE_SELECT, 8'(k));
			wr(`OFS_UNIT_CONTROL, 8'h85);
			run <= 1'b1;
			repeat (k * 3 + 5) @(posedge sys_clk_i);
			run <= 1'b0;
			e0 = ev_cnt;
			a0 = adc_cnt;
			src <= 8'h01 << ((k + 1) % 8);
			@(posedge sys_clk_i);
			src <= 8'h00;
			repeat (3) @(posedge sys_clk_i);
			chk(ev_cnt - e0, 0);
			src <= 8'h01 << k;
			repeat (3) @(posedge sys_clk_i);
			src <= 8'h00;
			chk(ev_cnt - e0, 1);
			chk(adc_cnt - a0, 0);
			rdc(`OFS_VALUE_LOW, {24'h0, t1.timer_one_low});
			rdc(`OFS_VALUE_HIGH, {24'h0, t1.timer_one_high});
		end
		rdc(`OFS_IRQ_STATUS, 32'h1);
		wr(`OFS_IRQ_MASK, 8'h01);
		repeat (3) @(negedge sys_clk_i);
		chk({31'h0, irq}, 32'h1);
		wr(`OFS_IRQ_MASK, 8'h00);
		repeat (3) @(negedge sys_clk_i);
		chk({31'h0, irq}, 32'h0);
		wr(`OFS_IRQ_MASK, 8'h01);
		wr(`OFS_IRQ_STATUS, 8'h01);
		rdc(`OFS_IRQ_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// capture edge modes and prescaling on the pin, then disabled and mode-off rows
		wr(`OFS_CAPTURE_SELECT, 8'h00);
		adc_sel <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			wr(`OFS_UNIT_CONTROL, pc_ctrl[i]);
			e0 = ev_cnt;
			a0 = adc_cnt;
			repeat (16) begin
				src <= 8'h01;
				repeat (2) @(posedge sys_clk_i);
				src <= 8'h00;
				repeat (2) @(posedge sys_clk_i);
			end
			repeat (3) @(posedge sys_clk_i);
			chk(ev_cnt - e0, pc_exp[i]);
			chk(adc_cnt - a0, pc_exp[i]);
		end
		// compare modes, each started from a cleared timer
		wr(`OFS_VALUE_LOW, 8'h20);
		wr(`OFS_VALUE_HIGH, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(`OFS_UNIT_CONTROL, 8'h00);
			tclr <= 1'b1;
			run  <= 1'b1;
			@(posedge sys_clk_i);
			tclr <= 1'b0;
			wr(`OFS_UNIT_CONTROL, {4'h8, cm_mode[i]});
			e0 = ev_cnt;
			h0 = hi_cnt;
			c0 = clr_cnt;
			repeat (45) @(posedge sys_clk_i);
			chk(ev_cnt - e0, 1);
			chk(clr_cnt - c0, cm_clr[i]);
			chk({31'h0, uout}, {31'h0, cm_out[i]});
			if (cm_mode[i] >= 4'ha) begin
				chk(hi_cnt - h0, 1);
			end
			rdc(`OFS_UNIT_CONTROL, {24'h0, 2'b10, cm_out[i], 1'b0, cm_mode[i]});
		end
		// pwm width per period in both alignments
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_VALUE_HIGH, pw_hi[i]);
			wr(`OFS_VALUE_LOW, pw_lo[i]);
			wr(`OFS_UNIT_CONTROL, pw_ctrl[i]);
			repeat (130) @(posedge sys_clk_i);
			e0 = ev_cnt;
			h0 = hi_cnt;
			repeat (64) @(posedge sys_clk_i);
			chk(hi_cnt - h0, pw_duty[i]);
			chk(ev_cnt - e0, 1);
		end
		wrap_up();
	end

endmodule

`default_nettype wire
